// file: design/t2crc_pkg.sv
// Package with register map, field layout and timing constants of the timer 2 block
package t2crc_pkg;
    localparam logic [7:0] CONTROL_OFS = 8'hC8;
    localparam logic [7:0] MODE_OFS = 8'hCC;
    localparam logic [7:0] CAP_LOW_OFS = 8'hD0;
    localparam logic [7:0] CAP_HIGH_OFS = 8'hD4;
    localparam logic [7:0] COUNT_LOW_OFS = 8'hD8;
    localparam logic [7:0] COUNT_HIGH_OFS = 8'hDC;

    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] CAP_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic MODE_UPDOWN_RST = 1'b0;

    localparam int MODE_UPDOWN_BIT = 0;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // Core clock cycles per internal timing tick
    localparam int TICK_DIV = 12;
    localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

    localparam int PIN_COUNT = 0;
    localparam int PIN_TRIGGER = 1;
    localparam int PIN_NUM = 2;

    localparam logic [1:0] SERIAL_MODE1 = 2'h1;
    localparam logic [1:0] SERIAL_MODE3 = 2'h3;

    typedef struct packed {
        logic overflow_flag;
        logic external_event_flag;
        logic receive_clock_select;
        logic transmit_clock_select;
        logic external_trigger_enable;
        logic run_control;
        logic counter_select;
        logic capture_reload_select;
    } t2crc_ctrl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } t2crc_word_t;
endpackage

// file: design/t2crc_top.sv
// Timer 2 capture/reload control block with APB register slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module t2crc_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_input_pin,
    input wire logic trigger_pin,
    input wire logic timer_irq_enable,
    input wire logic other_timer_overflow,
    input wire logic [1:0] serial_mode,
    output logic timer_irq,
    output logic rx_baud_pulse,
    output logic tx_baud_pulse
);

    // Shared register decode
    function automatic logic reg_hit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        reg_hit = (addr == ofs);
    endfunction

    t2crc_pkg::t2crc_ctrl_t ctrl;
    logic updown_enable;
    t2crc_pkg::t2crc_word_t cap;
    t2crc_pkg::t2crc_word_t count;

    logic [t2crc_pkg::PIN_NUM-1:0] pin_raw;
    logic [t2crc_pkg::PIN_NUM-1:0] pin_meta;
    logic [t2crc_pkg::PIN_NUM-1:0] pin_sync;
    logic [t2crc_pkg::PIN_NUM-1:0] pin_prev;
    logic [t2crc_pkg::PIN_NUM-1:0] pin_fall;

    logic [3:0] tick_cnt;
    logic tick;

    logic setup_phase;
    logic access_done;
    logic wr_en;
    logic mapped;
    logic [31:0] next_prdata;

    logic wr_control;
    logic wr_mode;
    logic wr_cap_low;
    logic wr_cap_high;
    logic wr_count_low;
    logic wr_count_high;

    logic serial_clocking;
    logic capture_mode;
    logic count_step;
    logic overflow;
    logic trigger_event;
    logic do_capture;
    logic do_reload;
    logic set_overflow_flag;
    logic set_event_flag;
    logic serial_mode_uses_timer;
    logic next_timer_irq;

    // Both pins arrive from outside, hence a two-flop synchroniser each
    assign pin_raw[t2crc_pkg::PIN_COUNT] = count_input_pin;
    assign pin_raw[t2crc_pkg::PIN_TRIGGER] = trigger_pin;

    genvar gi;
    generate
        for (gi = 0; gi < t2crc_pkg::PIN_NUM; gi++) begin : g_pin
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    pin_meta[gi] <= 1'b1;
                    pin_sync[gi] <= 1'b1;
                    pin_prev[gi] <= 1'b1;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                    pin_prev[gi] <= pin_sync[gi];
                end
            end
            assign pin_fall[gi] = pin_prev[gi] & ~pin_sync[gi];
        end
    endgenerate

    // Internal timing tick, one per machine cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tick_cnt <= 4'h0;
        end else if (tick_cnt == t2crc_pkg::TICK_LAST) begin
            tick_cnt <= 4'h0;
        end else begin
            tick_cnt <= tick_cnt + 4'h1;
        end
    end

    assign tick = (tick_cnt == t2crc_pkg::TICK_LAST);

    // APB slave: answer in the first access cycle, no wait states
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_en = access_done & pwrite & pstrb[0];

    assign mapped = reg_hit(paddr, t2crc_pkg::CONTROL_OFS)
        | reg_hit(paddr, t2crc_pkg::MODE_OFS)
        | reg_hit(paddr, t2crc_pkg::CAP_LOW_OFS)
        | reg_hit(paddr, t2crc_pkg::CAP_HIGH_OFS)
        | reg_hit(paddr, t2crc_pkg::COUNT_LOW_OFS)
        | reg_hit(paddr, t2crc_pkg::COUNT_HIGH_OFS);

    assign wr_control = wr_en & reg_hit(paddr, t2crc_pkg::CONTROL_OFS);
    assign wr_mode = wr_en & reg_hit(paddr, t2crc_pkg::MODE_OFS);
    assign wr_cap_low = wr_en & reg_hit(paddr, t2crc_pkg::CAP_LOW_OFS);
    assign wr_cap_high = wr_en & reg_hit(paddr, t2crc_pkg::CAP_HIGH_OFS);
    assign wr_count_low = wr_en & reg_hit(paddr, t2crc_pkg::COUNT_LOW_OFS);
    assign wr_count_high = wr_en & reg_hit(paddr, t2crc_pkg::COUNT_HIGH_OFS);

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (reg_hit(paddr, t2crc_pkg::CONTROL_OFS)) begin
            next_prdata[7:0] = ctrl;
        end else if (reg_hit(paddr, t2crc_pkg::MODE_OFS)) begin
            next_prdata[t2crc_pkg::MODE_UPDOWN_BIT] = updown_enable;
        end else if (reg_hit(paddr, t2crc_pkg::CAP_LOW_OFS)) begin
            next_prdata[7:0] = cap.low;
        end else if (reg_hit(paddr, t2crc_pkg::CAP_HIGH_OFS)) begin
            next_prdata[7:0] = cap.high;
        end else if (reg_hit(paddr, t2crc_pkg::COUNT_LOW_OFS)) begin
            next_prdata[7:0] = count.low;
        end else if (reg_hit(paddr, t2crc_pkg::COUNT_HIGH_OFS)) begin
            next_prdata[7:0] = count.high;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= ~mapped;
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Timer event decode
    assign serial_clocking = ctrl.receive_clock_select | ctrl.transmit_clock_select;
    assign capture_mode = ctrl.capture_reload_select & ~serial_clocking;

    assign count_step = ctrl.run_control
        & (ctrl.counter_select ? pin_fall[t2crc_pkg::PIN_COUNT] : tick);

    assign overflow = count_step & (count == t2crc_pkg::COUNT_MAX);

    assign trigger_event = ctrl.external_trigger_enable
        & pin_fall[t2crc_pkg::PIN_TRIGGER]
        & ~serial_clocking;

    assign do_capture = trigger_event & capture_mode;
    assign do_reload = ~capture_mode & (overflow | trigger_event);

    assign set_overflow_flag = overflow & ~serial_clocking;
    assign set_event_flag = trigger_event;

    // Control register; flags take a hardware set over a software clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl <= t2crc_pkg::CONTROL_RST;
        end else if (wr_control) begin
            ctrl <= pwdata[7:0];
            if (set_overflow_flag) begin
                ctrl.overflow_flag <= 1'b1;
            end
            if (set_event_flag) begin
                ctrl.external_event_flag <= 1'b1;
            end
        end else begin
            if (set_overflow_flag) begin
                ctrl.overflow_flag <= 1'b1;
            end
            if (set_event_flag) begin
                ctrl.external_event_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            updown_enable <= t2crc_pkg::MODE_UPDOWN_RST;
        end else if (wr_mode) begin
            updown_enable <= pwdata[t2crc_pkg::MODE_UPDOWN_BIT];
        end
    end

    // Capture/reload pair; a capture outranks a software write
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cap <= {t2crc_pkg::CAP_RST, t2crc_pkg::CAP_RST};
        end else if (do_capture) begin
            cap <= count;
        end else begin
            if (wr_cap_low) begin
                cap.low <= pwdata[7:0];
            end
            if (wr_cap_high) begin
                cap.high <= pwdata[7:0];
            end
        end
    end

    // Count register; software writes outrank hardware so a preset is never lost
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count <= {t2crc_pkg::COUNT_RST, t2crc_pkg::COUNT_RST};
        end else if (wr_count_low | wr_count_high) begin
            if (wr_count_low) begin
                count.low <= pwdata[7:0];
            end
            if (wr_count_high) begin
                count.high <= pwdata[7:0];
            end
        end else if (do_reload) begin
            count <= cap;
        end else if (count_step) begin
            count <= count + 16'h0001;
        end
    end

    // Interrupt request and serial baud pulses
    assign next_timer_irq = timer_irq_enable
        & (ctrl.overflow_flag
        | (ctrl.external_event_flag & ~updown_enable));

    assign serial_mode_uses_timer = (serial_mode == t2crc_pkg::SERIAL_MODE1)
        | (serial_mode == t2crc_pkg::SERIAL_MODE3);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= next_timer_irq;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_baud_pulse <= 1'b0;
        end else if (ctrl.receive_clock_select & serial_mode_uses_timer) begin
            rx_baud_pulse <= overflow;
        end else begin
            rx_baud_pulse <= other_timer_overflow;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_baud_pulse <= 1'b0;
        end else if (ctrl.transmit_clock_select & serial_mode_uses_timer) begin
            tx_baud_pulse <= overflow;
        end else begin
            tx_baud_pulse <= other_timer_overflow;
        end
    end

endmodule

`default_nettype wire

// file: tb/t2crc_pins.sv
// Far-side model of the count input and trigger pins
`timescale 1ns/1ps
`default_nettype none
module t2crc_pins (
    input wire logic clk_sys,
    output var logic count_input_pin,
    output var logic trigger_pin
);
    // Pull-ups hold both pins high while nothing drives them low
    initial begin
        count_input_pin = 1'b1;
        trigger_pin = 1'b1;
    end
    // Low and high phases of four cycles outlast the two-flop synchroniser
    task automatic pulse(input bit trig);
        @(posedge clk_sys);
        if (trig) trigger_pin <= 1'b0;
        else count_input_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        trigger_pin <= 1'b1;
        count_input_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// file: tb/t2crc_top_sva.sv
// Port checker for the timer 2 control block
`timescale 1ns/1ps
`default_nettype none
module t2crc_check (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_irq_enable,
    input wire logic other_timer_overflow,
    input wire logic [1:0] serial_mode,
    input wire logic timer_irq,
    input wire logic rx_baud_pulse,
    input wire logic tx_baud_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic mapped;
    assign mapped = paddr inside {8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hD8, 8'hDC};
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_on_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("error response wrong for address");
    a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read lanes not zero");
    a_rx_other_timer: assert property (!serial_mode[0] |=> rx_baud_pulse == $past(other_timer_overflow))
        else $error("receive clock not from other timer");
    a_tx_other_timer: assert property (!serial_mode[0] |=> tx_baud_pulse == $past(other_timer_overflow))
        else $error("transmit clock not from other timer");
    a_irq_gated_off: assert property (!timer_irq_enable |=> !timer_irq)
        else $error("interrupt while disabled");
    a_irq_sw_clear: assert property ($fell(timer_irq) |-> !$past(timer_irq_enable) || $past(pready && pwrite, 2))
        else $error("interrupt dropped without software");
    c_irq: cover property ($rose(timer_irq));
    c_err: cover property (pslverr);
    c_baud: cover property (rx_baud_pulse && serial_mode[0]);
endmodule
bind t2crc_top t2crc_check chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_irq_enable(timer_irq_enable), .other_timer_overflow(other_timer_overflow),
    .serial_mode(serial_mode), .timer_irq(timer_irq), .rx_baud_pulse(rx_baud_pulse),
    .tx_baud_pulse(tx_baud_pulse));
`default_nettype wire

// file: tb/t2crc_top_test.sv
// Register-level testbench for the timer 2 control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
    $display("[FAIL] %s expected %h got %h", nm, ex, got); end end
module t2crc_top_test;
    logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, q;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [3:0] pstrb = 4'h1;
    logic timer_irq_enable = 1'b1, other_timer_overflow = 1'b0, e, seen, tx_seen;
    logic [1:0] serial_mode = 2'h0;
    wire logic pready, pslverr, cin, trig, timer_irq, rx_baud_pulse, tx_baud_pulse;
    int n_fail = 0, checked = 0, cycles = 0;
    always #50 clk_sys = ~clk_sys;
    t2crc_pins pins (.clk_sys(clk_sys), .count_input_pin(cin), .trigger_pin(trig));
    t2crc_top uut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_input_pin(cin), .trigger_pin(trig),
        .timer_irq_enable(timer_irq_enable), .other_timer_overflow(other_timer_overflow),
        .serial_mode(serial_mode), .timer_irq(timer_irq), .rx_baud_pulse(rx_baud_pulse),
        .tx_baud_pulse(tx_baud_pulse));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard well above the few hundred cycles the sequence needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        apb(1'b0, a, 8'h00);
        `CHK("read", ex, q)
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(8'hC8, 8'h00);
        rd(8'hD4, 8'h00);
        apb(1'b0, 8'hC4, 8'h00);
        `CHK("slverr", 1'b1, e)
        wr(8'hD0, 8'hF0);
        wr(8'hD4, 8'hFF);
        wr(8'hD8, 8'hF0);
        wr(8'hDC, 8'hFF);
        wr(8'hC8, 8'h04);
        repeat (260) @(posedge clk_sys);
        rd(8'hC8, 8'h84);
        rd(8'hDC, 8'hFF);
        `CHK("irq", 1'b1, timer_irq)
        wr(8'hC8, 8'h00);
        repeat (3) @(posedge clk_sys);
        `CHK("irq", 1'b0, timer_irq)
        wr(8'hD8, 8'h34);
        wr(8'hDC, 8'h12);
        wr(8'hC8, 8'h09);
        pins.pulse(1'b1);
        rd(8'hD0, 8'h34);
        rd(8'hD4, 8'h12);
        rd(8'hC8, 8'h49);
        `CHK("irq", 1'b1, timer_irq)
        // Dropping the enable must silence the request while the flag stays set
        timer_irq_enable <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK("irq_gated", 1'b0, timer_irq)
        timer_irq_enable <= 1'b1;
        wr(8'hCC, 8'h01);
        repeat (3) @(posedge clk_sys);
        `CHK("irq", 1'b0, timer_irq)
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h01);
        wr(8'hD8, 8'h78);
        pins.pulse(1'b1);
        rd(8'hD0, 8'h34);
        // A write without the low byte strobe must leave the register alone
        pstrb <= 4'h0;
        wr(8'hD0, 8'h55);
        pstrb <= 4'h1;
        rd(8'hD0, 8'h34);
        wr(8'hC8, 8'h08);
        pins.pulse(1'b1);
        rd(8'hD8, 8'h34);
        rd(8'hC8, 8'h48);
        wr(8'hD8, 8'h00);
        wr(8'hC8, 8'h06);
        repeat (3) pins.pulse(1'b0);
        rd(8'hD8, 8'h03);
        wr(8'hC8, 8'h02);
        pins.pulse(1'b0);
        rd(8'hD8, 8'h03);
        wr(8'hD0, 8'hFE);
        wr(8'hD4, 8'hFF);
        wr(8'hD8, 8'hFE);
        wr(8'hDC, 8'hFF);
        // Trigger enable stays set so the serial-clocking gate on the trigger is exercised
        wr(8'hC8, 8'h3D);
        for (int m = 1; m <= 3; m += 2) begin
            serial_mode <= 2'(m);
            seen = 1'b0;
            tx_seen = 1'b0;
            for (int k = 0; k < 100 && !seen; k++) begin
                @(posedge clk_sys);
                seen = rx_baud_pulse;
                tx_seen = tx_baud_pulse;
            end
            `CHK("rx_baud", 1'b1, seen)
            `CHK("tx_baud", 1'b1, tx_seen)
        end
        pins.pulse(1'b1);
        rd(8'hC8, 8'h3D);
        rd(8'hDC, 8'hFF);
        // Mode 2 keeps the other timer as baud source despite both selects
        serial_mode <= 2'h2;
        @(posedge clk_sys);
        other_timer_overflow <= 1'b1;
        @(posedge clk_sys);
        other_timer_overflow <= 1'b0;
        @(posedge clk_sys);
        `CHK("rx_other", 1'b1, rx_baud_pulse)
        `CHK("tx_other", 1'b1, tx_baud_pulse)
        repeat (3) @(posedge clk_sys);
        summarize();
    end
endmodule
`default_nettype wire
